// ---- hdl/osam_pkg.sv ----
// Package with constants and types for the output switch and alarm menu block.
package osam_pkg;

   // Base clock rate in Hz.
   localparam int unsigned CLK_HZ          = 125_000_000;
   // Timing figures in their own units.
   localparam int unsigned ROLL_START_MS   = 1000;
   localparam int unsigned ROLL_FAST_MS    = 2000;
   localparam int unsigned ROLL_SLOW_MS    = 200;
   localparam int unsigned ROLL_QUICK_MS   = 50;
   localparam int unsigned EDIT_TMO_S      = 10;
   localparam int unsigned MENU_TMO_S      = 60;
   localparam int unsigned LONG_HOLD_MS    = 2000;
   // Cycles in one millisecond, derived from the rate.
   localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;

   // Value width of all measured values and limits.
   localparam int unsigned VAL_W           = 16;
   localparam int unsigned DLY_W           = 8;

   // Reset values of the stored parameters.
   localparam logic [VAL_W-1:0] ON_PT_RST  = 16'h0000;
   localparam logic [VAL_W-1:0] OFF_PT_RST = 16'h0000;
   localparam logic [VAL_W-1:0] HI_LIM_RST = 16'h7FFF;
   localparam logic [VAL_W-1:0] LO_LIM_RST = 16'h8000;
   localparam logic [DLY_W-1:0] DLY_RST    = 8'h00;
   // Delay parameter range in seconds.
   localparam logic [DLY_W-1:0] DLY_MAX    = 8'hFF;

   // Output function choices.
   typedef enum logic [1:0] {
      OSAM_FN_NONE,
      OSAM_FN_TWO_POINT,
      OSAM_FN_ALARM
   } osam_fn_t;

   // Parameter items of both menus.
   typedef enum logic [3:0] {
      OSAM_IT_FUNC,
      OSAM_IT_ON,
      OSAM_IT_OFF,
      OSAM_IT_SDLY,
      OSAM_IT_SERR,
      OSAM_IT_HI,
      OSAM_IT_LO,
      OSAM_IT_ADLY
   } osam_item_t;

   // Front-panel buttons as one group.
   typedef struct packed {
      logic rear;
      logic cancel;
      logic down;
      logic up;
      logic next;
   } osam_btn_t;

   // Display state reported outward.
   typedef struct packed {
      logic       menu_open;
      logic       cfg_menu;
      logic       editing;
      osam_item_t item;
      logic [VAL_W-1:0] value;
   } osam_disp_t;

endpackage : osam_pkg

// ---- hdl/osam_top.sv ----
// Menu and change-over output logic of the output switch and alarm block.
`timescale 1ns/100ps

// What this block does
// RULE1: Next button steps to next parameter name.
// RULE2: Next while editing stores value, back to name.
// RULE3: Up/down step by one; enter editing.
// RULE4: Hold over 1 s rolls, later faster.
// RULE5: Stepping past a limit wraps around.
// RULE6: Cancel discards edit; in names closes menu.
// RULE7: Ten idle seconds in editing abandon edit.
// RULE8: Sixty idle seconds close any menu.
// RULE9: Long next hold opens limit menu.
// RULE10: Limit menu refused when function is none.
// RULE11: Two-point config: on, off, delay, error, function.
// RULE12: Switch delay set and applied in seconds.
// RULE13: Error forces output per error preference.
// RULE14: Config-only items absent from limit menu.
// RULE15: Two-point limit menu alternates on, off.
// RULE16: Below on point on, above off point off.
// RULE17: Alarm config: high, low, delay, function.
// RULE18: Alarm after limit exceeded for full delay.
// RULE19: Alarm output active while no alarm.
// RULE20: Alarm limit menu: high, low, delay, wrap.
// RULE21: Rear plus next hold opens config menu.
// RULE22: Function offers none, two-point, alarm.
// RULE23: Compare new samples in entered units.
module osam_top
#(
   parameter int unsigned SEC_CYCLES = osam_pkg::CLK_HZ
)
(
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_rst_b,
   input  wire osam_pkg::osam_btn_t       i_btn,
   input  wire logic [osam_pkg::VAL_W-1:0] i_meas,
   input  wire logic                      i_meas_vld,
   input  wire logic                      i_meas_err,
   output logic                           o_relay,
   output logic                           o_alarm_hi,
   output logic                           o_alarm_lo,
   output osam_pkg::osam_disp_t           o_disp
);
   import osam_pkg::*;

   localparam int unsigned MS_DIV = SEC_CYCLES / 1000 > 0 ? SEC_CYCLES / 1000 : 1;
   localparam int unsigned SEC_DIV = SEC_CYCLES > 0 ? SEC_CYCLES : 1;

   logic [1:0]            rst_sync_q;
   logic                  rst_b;
   osam_btn_t             btn_m_q, btn_q, btn_p_q;
   logic [31:0]           ms_cnt_q, sec_cnt_q;
   logic                  ms_tick, sec_tick;
   logic                  open_q, cfg_q, edit_q;
   osam_item_t            item_q;
   logic [VAL_W-1:0]      edit_val_q;
   logic [15:0]           hold_ms_q, roll_ms_q, idle_s_q;
   logic                  long_done_q;
   osam_fn_t              fn_q;
   logic [VAL_W-1:0]      on_pt_q, off_pt_q, hi_lim_q, lo_lim_q;
   logic [DLY_W-1:0]      sdly_q, adly_q;
   logic                  serr_q;
   logic                  p_next, p_up, p_down, p_cancel, any_p, step_up, step_dn;
   logic                  roll_ev, open_lim, open_cfg, hold_next;
   logic                  tp_state_q, tp_pend_q, hi_q, lo_q;
   logic                  hi_over_q, lo_over_q;
   logic [DLY_W-1:0]      tp_sec_q, hi_sec_q, lo_sec_q;
   logic [VAL_W-1:0]      lim_val;
   logic [VAL_W-1:0]      lim_max, lim_min;

   // Reset is released through two flops so all logic leaves reset together.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b) rst_sync_q <= 2'b00;
      else          rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_b = rst_sync_q[1];

   // Buttons come from pins, so two flops precede any use; a third gives edges.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         btn_m_q <= '0;
         btn_q   <= '0;
         btn_p_q <= '0;
      end
      else
      begin
         btn_m_q <= i_btn;
         btn_q   <= btn_m_q;
         btn_p_q <= btn_q;
      end
   end
   assign p_next   = btn_q.next   & ~btn_p_q.next;
   assign p_up     = btn_q.up     & ~btn_p_q.up;
   assign p_down   = btn_q.down   & ~btn_p_q.down;
   assign p_cancel = btn_q.cancel & ~btn_p_q.cancel;
   assign any_p    = p_next | p_up | p_down | p_cancel;

   // Millisecond and second enables from two separate clock-cycle counters.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ms_cnt_q  <= '0;
         sec_cnt_q <= '0;
      end
      else
      begin
         ms_cnt_q  <= ms_tick ? '0 : ms_cnt_q + 32'h0000_0001;
         sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 32'h0000_0001;
      end
   end
   assign ms_tick  = (ms_cnt_q == 32'(MS_DIV - 1));
   assign sec_tick = (sec_cnt_q == 32'(SEC_DIV - 1));

   // Hold timing for roll and long presses; a long press fires once per hold.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold_ms_q   <= '0;
         roll_ms_q   <= '0;
         long_done_q <= 1'b0;
      end
      else if (!(btn_q.up | btn_q.down | btn_q.next))
      begin
         hold_ms_q   <= '0;
         roll_ms_q   <= '0;
         long_done_q <= 1'b0;
      end
      else
      begin
         if (ms_tick && hold_ms_q != 16'hFFFF) hold_ms_q <= hold_ms_q + 16'h0001;
         if (roll_ev) roll_ms_q <= '0;
         else if (ms_tick) roll_ms_q <= roll_ms_q + 16'h0001;
         if (open_lim || open_cfg) long_done_q <= 1'b1;
      end
   end
   // Roll starts after one second, and repeats faster after a further hold.
   assign roll_ev = edit_q && (btn_q.up ^ btn_q.down) && ms_tick    // RULE4
                    && hold_ms_q > 16'(ROLL_START_MS)
                    && roll_ms_q >= (hold_ms_q > 16'(ROLL_FAST_MS)
                                     ? 16'(ROLL_QUICK_MS) : 16'(ROLL_SLOW_MS));
   assign hold_next = btn_q.next && !long_done_q && hold_ms_q > 16'(LONG_HOLD_MS);
   // Limit menu needs next alone; the config menu needs the rear button too.
   assign open_lim  = !open_q && hold_next && !btn_q.rear
                      && fn_q != OSAM_FN_NONE;                       // RULE9 RULE10
   assign open_cfg  = !open_q && hold_next && btn_q.rear;           // RULE21
   assign step_up   = edit_q ? (p_up   | (roll_ev & btn_q.up))   : 1'b0;
   assign step_dn   = edit_q ? (p_down | (roll_ev & btn_q.down)) : 1'b0;

   // Range of the item under edit, used for the wrap on overflow.
   always_comb
   begin
      lim_min = '0;
      lim_max = 16'hFFFF;
      lim_val = on_pt_q;
      case (item_q)
         OSAM_IT_FUNC: begin lim_max = 16'h0002; lim_val = 16'(fn_q); end
         OSAM_IT_ON:   lim_val = on_pt_q;
         OSAM_IT_OFF:  lim_val = off_pt_q;
         OSAM_IT_SDLY: begin lim_max = 16'(DLY_MAX); lim_val = 16'(sdly_q); end
         OSAM_IT_SERR: begin lim_max = 16'h0001; lim_val = 16'(serr_q); end
         OSAM_IT_HI:   lim_val = hi_lim_q;
         OSAM_IT_LO:   lim_val = lo_lim_q;
         OSAM_IT_ADLY: begin lim_max = 16'(DLY_MAX); lim_val = 16'(adly_q); end
         default:      lim_val = '0;
      endcase
   end

   // Idle counter in seconds; a press of next, up, down or cancel restarts it.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)                      idle_s_q <= '0;
      else if (!open_q || any_p)       idle_s_q <= '0;
      else if (p_up | p_down)          idle_s_q <= '0;
      else if (sec_tick && idle_s_q != 16'hFFFF) idle_s_q <= idle_s_q + 16'h0001;
   end

   // Menu navigation, editing and parameter store.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         open_q     <= 1'b0;
         cfg_q      <= 1'b0;
         edit_q     <= 1'b0;
         item_q     <= OSAM_IT_FUNC;
         edit_val_q <= '0;
         fn_q       <= OSAM_FN_NONE;
         on_pt_q    <= ON_PT_RST;
         off_pt_q   <= OFF_PT_RST;
         hi_lim_q   <= HI_LIM_RST;
         lo_lim_q   <= LO_LIM_RST;
         sdly_q     <= DLY_RST;
         adly_q     <= DLY_RST;
         serr_q     <= 1'b0;
      end
      else if (open_cfg)
      begin
         open_q <= 1'b1;
         cfg_q  <= 1'b1;
         edit_q <= 1'b0;
         item_q <= OSAM_IT_FUNC;                                     // RULE21
      end
      else if (open_lim)
      begin
         open_q <= 1'b1;
         cfg_q  <= 1'b0;
         edit_q <= 1'b0;
         item_q <= (fn_q == OSAM_FN_ALARM) ? OSAM_IT_HI : OSAM_IT_ON; // RULE14
      end
      else if (open_q)
      begin
         if (idle_s_q > 16'(MENU_TMO_S))
         begin
            open_q <= 1'b0;                                          // RULE8
            edit_q <= 1'b0;
         end
         else if (edit_q && idle_s_q > 16'(EDIT_TMO_S))
            edit_q <= 1'b0;                                          // RULE7
         else if (edit_q)
         begin
            if (p_cancel)
               edit_q <= 1'b0;                                       // RULE6
            else if (p_next)
            begin
               edit_q <= 1'b0;                                       // RULE2
               case (item_q)
                  OSAM_IT_FUNC: fn_q     <= osam_fn_t'(edit_val_q[1:0]); // RULE22
                  OSAM_IT_ON:   on_pt_q  <= edit_val_q;
                  OSAM_IT_OFF:  off_pt_q <= edit_val_q;
                  OSAM_IT_SDLY: sdly_q   <= edit_val_q[DLY_W-1:0];   // RULE12
                  OSAM_IT_SERR: serr_q   <= edit_val_q[0];
                  OSAM_IT_HI:   hi_lim_q <= edit_val_q;
                  OSAM_IT_LO:   lo_lim_q <= edit_val_q;
                  OSAM_IT_ADLY: adly_q   <= edit_val_q[DLY_W-1:0];
                  default:      ;
               endcase
            end
            else if (step_up)
               edit_val_q <= (edit_val_q == lim_max) ? lim_min      // RULE5
                             : edit_val_q + 16'h0001;                // RULE3
            else if (step_dn)
               edit_val_q <= (edit_val_q == lim_min) ? lim_max      // RULE5
                             : edit_val_q - 16'h0001;                // RULE3
         end
         else if (p_cancel)
            open_q <= 1'b0;                                          // RULE6
         else if (p_up || p_down)
         begin
            edit_q     <= 1'b1;                                      // RULE3
            edit_val_q <= lim_val;
         end
         else if (p_next)
         begin
            // Sequence depends on the menu and on the stored function.
            case (item_q)
               OSAM_IT_FUNC: item_q <= (fn_q == OSAM_FN_ALARM) ? OSAM_IT_HI
                                     : (fn_q == OSAM_FN_TWO_POINT) ? OSAM_IT_ON
                                     : OSAM_IT_FUNC;                 // RULE1
               OSAM_IT_ON:   item_q <= OSAM_IT_OFF;                  // RULE11 RULE15
               OSAM_IT_OFF:  item_q <= cfg_q ? OSAM_IT_SDLY : OSAM_IT_ON; // RULE15
               OSAM_IT_SDLY: item_q <= OSAM_IT_SERR;                 // RULE11
               OSAM_IT_SERR: item_q <= OSAM_IT_FUNC;                 // RULE11
               OSAM_IT_HI:   item_q <= OSAM_IT_LO;                   // RULE17 RULE20
               OSAM_IT_LO:   item_q <= OSAM_IT_ADLY;
               OSAM_IT_ADLY: item_q <= cfg_q ? OSAM_IT_FUNC : OSAM_IT_HI; // RULE17 RULE20
               default:      item_q <= OSAM_IT_FUNC;
            endcase
         end
      end
   end

   // Two-point control with a whole-second delay before a new state takes effect.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tp_state_q <= 1'b0;
         tp_pend_q  <= 1'b0;
         tp_sec_q   <= '0;
      end
      else if (fn_q != OSAM_FN_TWO_POINT)
      begin
         tp_state_q <= 1'b0;
         tp_pend_q  <= 1'b0;
         tp_sec_q   <= '0;
      end
      else
      begin
         if (i_meas_vld)                                             // RULE23
         begin
            if ($signed(i_meas) < $signed(on_pt_q))       tp_pend_q <= 1'b1; // RULE16
            else if ($signed(i_meas) > $signed(off_pt_q)) tp_pend_q <= 1'b0; // RULE16
         end
         if (tp_pend_q == tp_state_q)
            tp_sec_q <= '0;
         else if (tp_sec_q >= sdly_q)
         begin
            tp_state_q <= tp_pend_q;                                 // RULE12
            tp_sec_q   <= '0;
         end
         else if (sec_tick)
            tp_sec_q <= tp_sec_q + 8'h01;
      end
   end

   // Limit state of the latest sample; it holds between samples.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hi_over_q <= 1'b0;
         lo_over_q <= 1'b0;
      end
      else if (fn_q != OSAM_FN_ALARM)
      begin
         hi_over_q <= 1'b0;
         lo_over_q <= 1'b0;
      end
      else if (i_meas_vld)
      begin
         hi_over_q <= $signed(i_meas) > $signed(hi_lim_q);           // RULE23
         lo_over_q <= $signed(i_meas) < $signed(lo_lim_q);           // RULE23
      end
   end

   // Each limit must stay passed without break for the delay; seconds count
   // on every tick while passed, not only on ticks that meet a sample.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hi_q     <= 1'b0;
         hi_sec_q <= '0;
      end
      else if (!hi_over_q)
      begin
         hi_q     <= 1'b0;                                           // RULE18
         hi_sec_q <= '0;
      end
      else if (hi_sec_q >= adly_q)
         hi_q <= 1'b1;                                               // RULE18
      else if (sec_tick)
         hi_sec_q <= hi_sec_q + 8'h01;
   end

   // Minimum alarm qualifier, built like the maximum one.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lo_q     <= 1'b0;
         lo_sec_q <= '0;
      end
      else if (!lo_over_q)
      begin
         lo_q     <= 1'b0;                                           // RULE18
         lo_sec_q <= '0;
      end
      else if (lo_sec_q >= adly_q)
         lo_q <= 1'b1;                                               // RULE18
      else if (sec_tick)
         lo_sec_q <= lo_sec_q + 8'h01;
   end

   // Output stage; all outputs come straight from flops.
   always_ff @(posedge i_sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         o_relay    <= 1'b0;
         o_alarm_hi <= 1'b0;
         o_alarm_lo <= 1'b0;
         o_disp     <= '0;
      end
      else
      begin
         case (fn_q)
            OSAM_FN_TWO_POINT: o_relay <= i_meas_err ? serr_q : tp_state_q; // RULE13
            OSAM_FN_ALARM:     o_relay <= !(hi_q || lo_q || i_meas_err);   // RULE19
            default:           o_relay <= 1'b0;                            // RULE22
         endcase
         o_alarm_hi <= (fn_q == OSAM_FN_ALARM) && (hi_q || i_meas_err);
         o_alarm_lo <= (fn_q == OSAM_FN_ALARM) && (lo_q || i_meas_err);
         o_disp.menu_open <= open_q;
         o_disp.cfg_menu  <= cfg_q;
         o_disp.editing   <= edit_q;
         o_disp.item      <= item_q;
         o_disp.value     <= edit_q ? edit_val_q : lim_val;
      end
   end

   // Assertions guarding the output and menu behaviour.
   a_alarm_inverted: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE19
      (fn_q == OSAM_FN_ALARM && !i_meas_err && !hi_q && !lo_q) |=> o_relay)
      else $error("alarm output not active without alarm");
   a_none_off: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE22
      (fn_q == OSAM_FN_NONE) |=> !o_relay)
      else $error("output on with no function");
   a_err_pref: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE13
      (fn_q == OSAM_FN_TWO_POINT && i_meas_err) |=> (o_relay == $past(serr_q)))
      else $error("error preference not applied");
   a_lim_refused: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE10
      (!open_q && fn_q == OSAM_FN_NONE && !btn_q.rear) |=> !open_q)
      else $error("limit menu opened with no function");
   a_cancel_keep: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE6
      (edit_q && p_cancel && !open_cfg && !open_lim) |=> (!edit_q && $stable(on_pt_q)))
      else $error("cancel did not discard edit");
   a_cancel_close: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE6
      (open_q && !edit_q && p_cancel && idle_s_q <= 16'(MENU_TMO_S)) |=> !open_q)
      else $error("cancel did not close menu");
   a_store_next: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE2
      (open_q && edit_q && p_next && item_q == OSAM_IT_ON
       && idle_s_q <= 16'(EDIT_TMO_S)) |=> (!edit_q && on_pt_q == $past(edit_val_q)))
      else $error("next did not store value");
   a_edit_tmo: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE7
      (edit_q && idle_s_q > 16'(EDIT_TMO_S)) |=> !edit_q)
      else $error("edit timeout missed");
   a_menu_tmo: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE8
      (open_q && idle_s_q > 16'(MENU_TMO_S)) |=> !open_q)
      else $error("menu timeout missed");
   a_tp_wrap: assert property (@(posedge i_sys_clk) disable iff (!rst_b) // RULE15
      (open_q && !cfg_q && !edit_q && p_next && item_q == OSAM_IT_OFF
       && !p_cancel && !p_up && !p_down
       && idle_s_q <= 16'(MENU_TMO_S)) |=> item_q == OSAM_IT_ON)
      else $error("two-point menu did not wrap");

endmodule : osam_top

// ---- testbench/osam_panel_model.sv ----
// Front-panel model: the push buttons that face the menu logic.
`timescale 1ns/100ps
module osam_panel_model
(
   input  wire logic               i_sys_clk,
   input  wire osam_pkg::osam_btn_t i_want,
   output osam_pkg::osam_btn_t     o_btn
);
   import osam_pkg::*;

   // Contacts move at the falling edge so the design never samples a change on its own edge.
   always @(negedge i_sys_clk)
   begin
      o_btn <= i_want;
   end
endmodule : osam_panel_model

// ---- testbench/osam_top_tb_top.sv ----
// Self-checking bench for the menu and change-over output block.
`timescale 1ns/100ps
module osam_top_tb_top;
   import osam_pkg::*;
   localparam int unsigned SECS = 1000;
   localparam osam_btn_t   B_NX = 5'h01;
   localparam osam_btn_t   B_UP = 5'h02;
   localparam osam_btn_t   B_DN = 5'h04;
   localparam osam_btn_t   B_CN = 5'h08;
   localparam osam_btn_t   B_RN = 5'h11;
   logic             clk;
   logic             rst_b;
   logic             vld;
   logic             err;
   logic             relay;
   logic             ahi;
   logic             alo;
   logic             exp_rel;
   logic [VAL_W-1:0] meas;
   osam_btn_t        want;
   osam_btn_t        btn;
   osam_disp_t       disp;
   int               fails;
   int               num_checks;
   int               cyc;
   int               r;

   osam_panel_model panel (.i_sys_clk(clk), .i_want(want), .o_btn(btn));
   osam_top #(.SEC_CYCLES(SECS)) dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_btn(btn),
      .i_meas(meas), .i_meas_vld(vld), .i_meas_err(err), .o_relay(relay),
      .o_alarm_hi(ahi), .o_alarm_lo(alo), .o_disp(disp));

   // Free-running 125 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic final_report();
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Hold a button group for n cycles, then give the design time to settle.
   task automatic press(input osam_btn_t b, input int n);
      @(posedge clk);
      want = b;
      repeat (n) @(posedge clk);
      want = 5'h00;
      repeat (8) @(negedge clk);
   endtask : press

   // One sample pulse, then the relay is compared once it has followed.
   task automatic sample(input logic [15:0] v, input logic e);
      @(negedge clk);
      meas = v;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      repeat (6) @(negedge clk);
      chk("o_relay", {31'h0000_0000, e}, {31'h0000_0000, relay});
   endtask : sample

   // Expected hysteresis state; the state holds between the two points.
   function automatic logic hyst(input logic q, input logic signed [15:0] v,
                                 input logic signed [15:0] on, input logic signed [15:0] off);
      if (v < on)
         return 1'b1;
      if (v > off)
         return 1'b0;
      return q;
   endfunction : hyst

   // Hang guard: the whole run takes about 83000 cycles, most of it the menu idle wait, below this ceiling.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         fails++;
         final_report();
      end
   end

   initial
   begin
      rst_b = 1'b0;
      want = 5'h00;
      meas = 16'h0000;
      vld = 1'b0;
      err = 1'b0;
      exp_rel = 1'b0;
      fails = 0;
      num_checks = 0;
      cyc = 0;
      void'($urandom(92850));
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chk("reset out", 32'h0000_0000, {relay, ahi, alo, disp.menu_open});
      press(B_NX, 2100);
      chk("menu_open", 32'h0000_0000, disp.menu_open);
      press(B_RN, 2100);
      chk("cfg open", {1'b1, 1'b1, OSAM_IT_FUNC}, {disp.menu_open, disp.cfg_menu, disp.item});
      press(B_UP, 4);
      press(B_UP, 4);
      chk("fn edit", 32'h0000_0001, disp.value);
      press(B_CN, 4);
      chk("fn cancel", 32'h0000_0000, {disp.editing, disp.value});
      press(B_UP, 4);
      for (int k = 1; k <= 4; k++)
      begin
         press(B_UP, 4);
         chk("fn step", k % 3, disp.value);
      end
      press(B_NX, 4);
      chk("fn store", 32'h0000_0001, {disp.editing, disp.value});
      press(B_NX, 4);
      chk("item", OSAM_IT_ON, disp.item);
      press(B_DN, 4);
      press(B_DN, 4);
      press(B_NX, 4);
      chk("on wrap", 32'h0000_FFFF, disp.value);
      press(B_NX, 4);
      press(B_UP, 4);
      press(B_UP, 4);
      press(B_NX, 4);
      press(B_NX, 4);
      chk("item", OSAM_IT_SDLY, disp.item);
      press(B_NX, 4);
      press(B_UP, 4);
      press(B_UP, 4);
      press(B_NX, 4);
      press(B_NX, 4);
      chk("item", OSAM_IT_FUNC, disp.item);
      press(B_CN, 4);
      chk("menu_open", 32'h0000_0000, disp.menu_open);
      // Random samples from -8 to +8 around the points at -1 and +1; the edges are not forced among them.
      sample(16'hFFFE, 1'b1);
      exp_rel = 1'b1;
      repeat (20)
      begin
         r = int'($urandom_range(16)) - 8;
         exp_rel = hyst(exp_rel, 16'(r), 16'hFFFF, 16'h0001);
         sample(16'(r), exp_rel);
      end
      err = 1'b1;
      repeat (6) @(negedge clk);
      chk("err relay", 32'h0000_0001, relay);
      err = 1'b0;
      sample(16'h0005, 1'b0);
      press(B_NX, 2100);
      chk("lim open", {1'b1, 1'b0, OSAM_IT_ON}, {disp.menu_open, disp.cfg_menu, disp.item});
      press(B_UP, 4);
      repeat (12 * SECS + 100) @(negedge clk);
      chk("edit drop", {1'b0, 16'hFFFF}, {disp.editing, disp.value});
      press(B_NX, 4);
      chk("item", OSAM_IT_OFF, disp.item);
      press(B_NX, 4);
      chk("item", OSAM_IT_ON, disp.item);
      repeat (62 * SECS) @(negedge clk);
      chk("menu_open", 32'h0000_0000, disp.menu_open);
      // Switch to alarm mode and lower the high limit so that zero is over it.
      press(B_RN, 2100);
      press(B_UP, 4);
      press(B_UP, 4);
      press(B_NX, 4);
      press(B_NX, 4);
      chk("item", OSAM_IT_HI, disp.item);
      sample(16'h0000, 1'b1);
      press(B_UP, 4);
      press(B_UP, 4);
      press(B_NX, 4);
      sample(16'h0000, 1'b0);
      chk("alarm_hi", 32'h0000_0002, {ahi, alo});
      final_report();
   end
endmodule : osam_top_tb_top
